/* File: core/ircf_map.svh */
`ifndef IRCF_MAP_SVH
`define IRCF_MAP_SVH

// Pass timing
`define IRCF_NUM_FUNCS     12
`define IRCF_PERIOD_NS     1300000
`define IRCF_CLK_PERIOD_NS 10
`define IRCF_PERIOD_CYCLES (`IRCF_PERIOD_NS / `IRCF_CLK_PERIOD_NS)

// APB byte offsets
`define IRCF_MOTOR_BASE    12'h000
`define IRCF_CFG_BASE      12'h400
`define IRCF_STATUS_OFS    12'h440
`define IRCF_CTRL_OFS      12'h444

// Reset values
`define IRCF_CFG_RESET     32'h0000_0000
`define IRCF_CTRL_RESET    1'b1

// Configuration word fields
`define IRCF_INSEL_MSB     7
`define IRCF_INSEL_LSB     4

// Target codes
`define IRCF_CODE_NONE     4'h0
`define IRCF_CODE_MODE     4'h1
`define IRCF_CODE_VEL      4'h2
`define IRCF_CODE_POS      4'h3
`define IRCF_CODE_ACC      4'h4
`define IRCF_CODE_TRQ      4'h5
`define IRCF_CODE_WIN      4'h6
`define IRCF_CODE_REG      4'h7

// Fixed target register numbers
`define IRCF_REG_MODE      8'h02
`define IRCF_REG_VEL       8'h03
`define IRCF_REG_POS       8'h04
`define IRCF_REG_ACC       8'h05
`define IRCF_REG_TRQ       8'h06
`define IRCF_REG_WIN       8'h07

// Source group bases, source register is base plus index
`define IRCF_GRP_MODE      8'h20
`define IRCF_GRP_VEL       8'h28
`define IRCF_GRP_POS       8'h30
`define IRCF_GRP_ACC       8'h38
`define IRCF_GRP_TRQ       8'h40
`define IRCF_GRP_WIN       8'h48

`endif

/* File: core/ircf_pkg.sv */
package ircf_pkg;

    // Pass sequencer states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } ircf_state_e;

    // One input_copy_function configuration word
    typedef struct packed {
        logic [7:0] dest;
        logic [7:0] srcHigh;
        logic [7:0] srcLow;
        logic [3:0] inSel;
        logic [3:0] tgtCode;
    } ircf_cfg_s;

    // Setpoint and mode registers seen by the motion logic
    typedef struct packed {
        logic [31:0] mode;
        logic [31:0] velocitySetpoint;
        logic [31:0] positionSetpoint;
        logic [31:0] accelSetpoint;
        logic [31:0] torqueSetpoint;
        logic [31:0] inPositionWindow;
    } ircf_targets_s;

endpackage

/* File: core/ircf_copier.sv */
// What this block does
// - A zero source or index for the present level means skip_copy.
// - All twelve functions run every 1.3 ms, from zero up to eleven.
// - No bus access interleaves a pass; inputs and registers stay fixed.
// - Later functions overwrite earlier ones writing the same target.
// - Any function may pick any input, shared inputs are allowed.
// - Bits 7 to 4 pick the digital input bit controlling the function.
// - Bits 3 to 0 pick the target; code 7 uses bits 31 to 24.
// - Bits 23:16 source for high, 15:8 for low; index or register.
`include "ircf_map.svh"

module ircf_copier
    import ircf_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = `IRCF_PERIOD_CYCLES,
    parameter int unsigned NUM_FUNCS     = `IRCF_NUM_FUNCS,
    parameter int unsigned DIN_WIDTH     = 16
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Digital input pins
    input  wire logic [DIN_WIDTH-1:0] digitalIn,
    // Targets and pass state
    output ircf_targets_s             targets,
    output logic                      passBusy
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam int unsigned CNT_W = $clog2(PERIOD_CYCLES + 1);
    localparam int unsigned IDX_W = $clog2(NUM_FUNCS + 1);

    // Register file and configuration words
    logic [31:0]          motorReg_q [256];
    logic [31:0]          cfg_q      [NUM_FUNCS];

    // Input capture
    logic [DIN_WIDTH-1:0] dinMeta_q;
    logic [DIN_WIDTH-1:0] dinSync_q;
    logic [DIN_WIDTH-1:0] dinSnap_q;

    // Timer and pass sequencer
    logic [CNT_W-1:0]     periodCnt_q;
    logic                 due_q;
    logic                 enable_q;
    ircf_state_e          state_q;
    ircf_state_e          state_d;
    logic [IDX_W-1:0]     funcIdx_q;

    // Bus answer
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // Register number decode, shared by source and destination

    function automatic logic [7:0] regNum(input logic [3:0] code,
                                          input logic [7:0] num,
                                          input logic       isDest);
        logic [7:0] fixedReg;
        logic [7:0] grpBase;
        fixedReg = 8'h00;
        grpBase  = 8'h00;
        // Fixed target and source group base of each code
        case (code)
            `IRCF_CODE_MODE: begin
                fixedReg = `IRCF_REG_MODE;
                grpBase  = `IRCF_GRP_MODE;
            end
            `IRCF_CODE_VEL: begin
                fixedReg = `IRCF_REG_VEL;
                grpBase  = `IRCF_GRP_VEL;
            end
            `IRCF_CODE_POS: begin
                fixedReg = `IRCF_REG_POS;
                grpBase  = `IRCF_GRP_POS;
            end
            `IRCF_CODE_ACC: begin
                fixedReg = `IRCF_REG_ACC;
                grpBase  = `IRCF_GRP_ACC;
            end
            `IRCF_CODE_TRQ: begin
                fixedReg = `IRCF_REG_TRQ;
                grpBase  = `IRCF_GRP_TRQ;
            end
            `IRCF_CODE_WIN: begin
                fixedReg = `IRCF_REG_WIN;
                grpBase  = `IRCF_GRP_WIN;
            end
            default: begin
                fixedReg = 8'h00;
                grpBase  = 8'h00;
            end
        endcase
        // Code 0, codes above 7 and a zero index give no register
        if (code == `IRCF_CODE_REG) begin
            regNum = num;
        end else if (fixedReg == 8'h00) begin
            regNum = 8'h00;
        end else if (isDest) begin
            regNum = fixedReg;
        end else if (num == 8'h00) begin
            regNum = 8'h00;
        end else begin
            regNum = 8'(grpBase + num);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire        apbAccess  = psel & penable;
    wire        isMotor    = (paddr[11:10] == 2'b00);
    wire        isCfg      = (paddr[11:6] == 6'(`IRCF_CFG_BASE >> 6))
                             && (paddr[5:2] < 4'(NUM_FUNCS));
    wire        isStatus   = (paddr[11:2] == 10'(`IRCF_STATUS_OFS >> 2));
    wire        isCtrl     = (paddr[11:2] == 10'(`IRCF_CTRL_OFS >> 2));
    wire        isMapped   = isMotor | isCfg | isStatus | isCtrl;
    wire [7:0]  motorIdx   = paddr[9:2];
    wire [3:0]  cfgIdx     = paddr[5:2];
    wire        apbCommit  = apbAccess & pready_q & pwrite;
    wire        running    = (state_q == ST_RUN);

    // Pass start waits for any bus answer in flight
    wire        passStart  = due_q & ~running & ~pready_q & enable_q;
    wire        ackSet     = apbAccess & ~pready_q & ~running
                             & ~passStart;

    // Read data selection
    wire [31:0] statusWord = {{(31 - DIN_WIDTH){1'b0}}, dinSnap_q,
                              running};
    wire [31:0] readData   = isMotor  ? motorReg_q[motorIdx]
                           : isCfg    ? cfg_q[cfgIdx]
                           : isStatus ? statusWord
                           : isCtrl   ? {31'h0, enable_q}
                           : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Current function decode

    ircf_cfg_s  curCfg;
    assign curCfg = ircf_cfg_s'(cfg_q[funcIdx_q]);

    wire        curLevel   = dinSnap_q[curCfg.inSel];
    wire [7:0]  curSrcSel  = curLevel ? curCfg.srcHigh
                                      : curCfg.srcLow;
    wire [7:0]  srcNum     = regNum(curCfg.tgtCode, curSrcSel, 1'b0);
    wire [7:0]  dstNum     = regNum(curCfg.tgtCode, curCfg.dest, 1'b1);
    wire        doCopy     = running && (curSrcSel != 8'h00)
                             && (srcNum != 8'h00)
                             && (dstNum != 8'h00);
    wire        lastFunc   = (funcIdx_q == IDX_W'(NUM_FUNCS - 1));
    wire        periodWrap = (periodCnt_q == CNT_W'(PERIOD_CYCLES - 1));

    // Next values of the timer and the sequencer
    wire [CNT_W-1:0] periodCnt_d = periodWrap ? '0
                                   : CNT_W'(periodCnt_q + 1'b1);
    wire             due_d       = enable_q
                                   & (periodWrap | (due_q & ~passStart));
    wire [IDX_W-1:0] funcIdx_d   = (running && !lastFunc)
                                   ? IDX_W'(funcIdx_q + 1'b1) : '0;

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser

    // Only the second stage is read by the logic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dinMeta_q <= '0;
            dinSync_q <= '0;
        end else begin
            dinMeta_q <= digitalIn;
            dinSync_q <= dinMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Period timer and pending pass flag

    // A wrap in the start cycle keeps the flag set
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            periodCnt_q <= '0;
            due_q       <= 1'b0;
        end else begin
            periodCnt_q <= periodCnt_d;
            due_q       <= due_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pass sequencer

    always_comb begin
        case (state_q)
            ST_IDLE: begin
                state_d = passStart ? ST_RUN : ST_IDLE;
            end
            ST_RUN: begin
                state_d = lastFunc ? ST_IDLE : ST_RUN;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // One function per cycle, ascending order
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= ST_IDLE;
            funcIdx_q <= '0;
            dinSnap_q <= '0;
        end else begin
            state_q   <= state_d;
            funcIdx_q <= funcIdx_d;
            // Inputs frozen for the whole pass
            if (passStart) begin
                dinSnap_q <= dinSync_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Motor register file, copy engine and bus writes

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 256; i++) begin
                motorReg_q[i] <= 32'h0000_0000;
            end
        end else if (doCopy) begin
            // A pass never shares a cycle with a bus write
            motorReg_q[dstNum] <= motorReg_q[srcNum];
        end else if (apbCommit && isMotor) begin
            motorReg_q[motorIdx] <= pwdata;
        end
    end

    // Configuration words and control
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_FUNCS; i++) begin
                cfg_q[i] <= `IRCF_CFG_RESET;
            end
            enable_q <= `IRCF_CTRL_RESET;
        end else if (apbCommit) begin
            if (isCfg) begin
                cfg_q[cfgIdx] <= pwdata;
            end
            if (isCtrl) begin
                enable_q <= pwdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer, held off for a whole pass

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            // Answer one cycle after the request is taken
            pready_q  <= ackSet;
            pslverr_q <= ackSet & ~isMapped;
            if (ackSet && !pwrite) begin
                prdata_q <= readData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign passBusy = running;
    // Setpoints straight from the fixed target registers
    assign targets  = '{
        mode:             motorReg_q[`IRCF_REG_MODE],
        velocitySetpoint: motorReg_q[`IRCF_REG_VEL],
        positionSetpoint: motorReg_q[`IRCF_REG_POS],
        accelSetpoint:    motorReg_q[`IRCF_REG_ACC],
        torqueSetpoint:   motorReg_q[`IRCF_REG_TRQ],
        inPositionWindow: motorReg_q[`IRCF_REG_WIN]
    };

endmodule

/* File: test/ircf_copier_properties.sv */
module ircf_copier_properties
    import ircf_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = 40,
    parameter int unsigned DIN_WIDTH     = 16
) (
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    // APB
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Pins and targets
    input wire logic [DIN_WIDTH-1:0] digitalIn,
    input wire ircf_targets_s        targets,
    input wire logic                 passBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PLO = PERIOD_CYCLES - 14;
    localparam int PHI = PERIOD_CYCLES + 14;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // APB phases
    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable;
    endsequence

    ////////////////////////////////////////////////////////////////////
    AST_PASS_LEN: assert property ($rose(passBusy) |->
        passBusy[*8] ##1 passBusy[*4] ##1 !passBusy)
        else $error("pass length wrong");
    AST_PASS_PERIOD: assert property ($rose(passBusy) |->
        ##[PLO:PHI] $rose(passBusy))
        else $error("pass period wrong");
    AST_NO_ACK_IN_PASS: assert property (passBusy |-> !pready)
        else $error("bus answered during pass");
    AST_TGT_HOLD: assert property (
        !passBusy && !(pready && pwrite) |=> $stable(targets))
        else $error("targets moved outside pass");
    AST_ACK_LATENCY: assert property (setupS ##1 accessS |-> ##[1:15] pready)
        else $error("bus answer too late");
    AST_ACK_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_ACK: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_MAPPED_NO_ERR: assert property (pready && paddr < 12'h430 |-> !pslverr)
        else $error("error on mapped address");
    AST_UNMAPPED_ZERO: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule

bind ircf_copier ircf_copier_properties #(
    .PERIOD_CYCLES(PERIOD_CYCLES),
    .DIN_WIDTH    (DIN_WIDTH)
) u_ircf_copier_properties (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .digitalIn(digitalIn),
    .targets  (targets),
    .passBusy (passBusy)
);

/* File: test/ircf_copier_tb.sv */
`include "ircf_map.svh"
module ircf_copier_tb
    import ircf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic e; logic r; logic [31:0] d;} ircf_note_s;
    logic          clk_sys, reset_n, psel, penable, pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, d;
    logic          pready, pslverr, passBusy;
    logic          busyQ = 1'b0;
    logic [15:0]   digitalIn;
    ircf_targets_s targets;
    ircf_cfg_s     c;
    ircf_note_s    nt;
    ircf_note_s    apbQ[$];
    ircf_targets_s tgtQ[$];
    logic [31:0]   mem [256];
    ircf_cfg_s     cfgM [12];
    int            n_mismatch, check_count;

    ircf_copier #(.PERIOD_CYCLES(40)) u_ircf_copier (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .digitalIn(digitalIn),
        .targets(targets), .passBusy(passBusy));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check32(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic checkTgt(input ircf_targets_s e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] targets exp %h got %h", e, g);
        end
    endtask

    // One APB transfer, expectation noted first
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, ed, input logic ee);
        apbQ.push_back('{ee, !w, ed});
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int i = 0; i <= 100; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
            if (i == 100) begin
                n_mismatch++;
                tally_and_finish();
            end
        end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Bounded wait for the edge after a pass ends
    task automatic waitEnd();
        logic b;
        b = 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys);
            if (b && passBusy === 1'b0) return;
            b = passBusy;
        end
        n_mismatch++;
        tally_and_finish();
    endtask

    // Reference pass over the shadow registers
    function automatic void runPass(input logic [15:0] din);
        logic [7:0] s, t;
        for (int k = 0; k < 12; k++) begin
            s = din[cfgM[k].inSel] ? cfgM[k].srcHigh : cfgM[k].srcLow;
            t = 8'h00;
            if (cfgM[k].tgtCode inside {[1:6]} && s != 8'h00) begin
                t = cfgM[k].tgtCode + 8'h01;
                s = s + `IRCF_GRP_MODE + 8 * (cfgM[k].tgtCode - 1);
            end else if (cfgM[k].tgtCode == 4'h7) t = cfgM[k].dest;
            if (t != 8'h00 && s != 8'h00) mem[t] = mem[s];
        end
    endfunction

    // Result watcher
    always @(posedge clk_sys) begin
        if (pready === 1'b1 && apbQ.size() > 0) begin
            nt = apbQ.pop_front();
            check32("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
            if (nt.r) check32("prdata", nt.d, prdata);
        end
        if (busyQ && passBusy === 1'b0 && tgtQ.size() > 0)
            checkTgt(tgtQ.pop_front(), targets);
        busyQ <= passBusy;
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; digitalIn = 16'h0000;
        n_mismatch = 0; check_count = 0;
        foreach (mem[i]) mem[i] = 32'h0;
        d = $urandom(32'hB725E3B4);
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        apb(0, `IRCF_CFG_BASE, 0, 0, 0);
        apb(0, `IRCF_CTRL_OFS, 0, 1, 0);
        apb(0, 12'h008, 0, 0, 0);
        apb(1, 12'h448, 32'h5, 0, 1);
        apb(0, 12'h448, 0, 0, 1);
        apb(0, 12'h430, 0, 0, 1);
        $display("reset and map test done");
        // Configs first, so passes during setup copy only zero sources
        for (int k = 0; k < 12; k++) begin
            c = $urandom;
            c.tgtCode = 4'((k < 8) ? k : $urandom_range(1, 8));
            c.inSel = 4'($urandom_range(0, 3));
            c.srcHigh = 8'($urandom_range(0, 7));
            c.srcLow = 8'($urandom_range(0, 7));
            c.dest = 8'($urandom_range(0, 7));
            if (c.tgtCode == 4'h7) begin
                c.srcHigh = c.srcHigh ? c.srcHigh + 8'h5C : 8'h00;
                c.srcLow = c.srcLow ? c.srcLow + 8'h5C : 8'h00;
            end
            cfgM[k] = c;
            apb(1, 12'(`IRCF_CFG_BASE + 4 * k), c, 0, 0);
            apb(0, 12'(`IRCF_CFG_BASE + 4 * k), 0, c, 0);
        end
        // Sources last; the next level-zero pass overwrites partial copies
        for (int n = 8'h21; n < 8'h64; n++) begin
            mem[n] = $urandom;
            apb(1, 12'(n * 4), mem[n], 0, 0);
        end
        runPass(16'h0000);
        $display("setup test done");
        for (int p = 0; p < 12; p++) begin
            waitEnd();
            @(posedge clk_sys);
            d = $urandom;
            digitalIn <= d[15:0];
            runPass(d[15:0]);
            tgtQ.push_back('{mem[2], mem[3], mem[4],
                             mem[5], mem[6], mem[7]});
        end
        waitEnd();
        @(posedge clk_sys);
        apb(1, `IRCF_STATUS_OFS, 32'hFFFF_FFFF, 0, 0);
        apb(0, `IRCF_STATUS_OFS, 0, {15'h0, d[15:0], 1'b0}, 0);
        $display("copy pass test done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        tgtQ.push_back('0);
        waitEnd();
        @(posedge clk_sys);
        apb(0, 12'h00C, 0, 0, 0);
        apb(0, `IRCF_CTRL_OFS, 0, 1, 0);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule
